// ==== wmsr_map.vh ====
// Constants and address map of the weather Modbus slave register bank
`ifndef WMSR_MAP_VH
`define WMSR_MAP_VH
`define WMSR_CLK_HZ 200000000
`define WMSR_BAUD 9600
`define WMSR_DEF_ADDR 8'hff
`define WMSR_FC_READ 8'h03
`define WMSR_REG_FIRST 16'h0001
`define WMSR_REG_LAST 16'h000b
// Register offsets, low nibble of the register address
`define WMSR_OFS_AIR_TEMPERATURE 4'h1
`define WMSR_OFS_AIR_HUMIDITY 4'h2
`define WMSR_OFS_AIR_PRESSURE 4'h3
`define WMSR_OFS_WIND_SPEED 4'h4
`define WMSR_OFS_WIND_DIRECTION 4'h5
`define WMSR_OFS_RAINFALL_TOTAL 4'h6
`define WMSR_OFS_SOLAR_RADIATION 4'h7
`define WMSR_OFS_ILLUMINATION 4'h8
`define WMSR_OFS_SUNSHINE_DURATION 4'h9
`define WMSR_OFS_DEW_POINT 4'ha
`define WMSR_OFS_EVAPOTRANSPIRATION 4'hb
`define WMSR_CRC_INIT 16'hffff
`define WMSR_CRC_POLY 16'ha001
`define WMSR_REQ_LEN 8
// Gap of 3.5 characters (about 4 ms) ends a frame
`define WMSR_GAP_US 4010
`endif

// ==== wmsr_slave.v ====
// Modbus RTU slave that serves the eleven read-only measurement registers
`timescale 1ns/1ps
`default_nettype none
`include "wmsr_map.vh"
module wmsr_slave #(
  parameter CLK_HZ = `WMSR_CLK_HZ,
  parameter BAUD = `WMSR_BAUD,
  parameter GAP_CYC = (`WMSR_GAP_US * (`WMSR_CLK_HZ / 1000000))
) (
  // Clock and reset
  input wire core_clk,
  input wire sys_rst,
  // Serial line
  input wire rx_pin,
  output reg tx_pin_q,
  output reg tx_oe_q,
  // Measurement values, already scaled and offset by the sensor path
  input wire [15:0] air_temperature,
  input wire [15:0] air_humidity,
  input wire [15:0] air_pressure,
  input wire [15:0] wind_speed,
  input wire [15:0] wind_direction,
  input wire [15:0] rainfall_total,
  input wire [15:0] solar_radiation,
  input wire [15:0] illumination,
  input wire [15:0] sunshine_duration,
  input wire [15:0] dew_point,
  input wire [15:0] evapotranspiration,
  // Status
  output reg busy_q
);
  // Bit time in clock cycles; half a bit centres the first sample
  localparam integer BIT_CYC = CLK_HZ / BAUD;
  localparam integer HALF_CYC = BIT_CYC / 2;
  // Transmit states, one-hot
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_LOAD = 4'b0010;
  localparam [3:0] ST_SEND = 4'b0100;
  localparam [3:0] ST_WAIT = 4'b1000;

  // One CRC16 step over a byte, reflected polynomial
  // Shared by the request check and the reply CRC
  function [15:0] crc_byte;
    input [15:0] crc;
    input [7:0] data;
    integer i;
    reg [15:0] c;
    begin
      c = crc ^ {8'h00, data};
      for (i = 0; i < 8; i = i + 1) begin
        if (c[0]) begin
          c = (c >> 1) ^ `WMSR_CRC_POLY;
        end else begin
          c = c >> 1;
        end
      end
      crc_byte = c;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Input synchroniser
  // Only the second flop feeds the receiver, so a metastable level settles first
  reg rx_s1_q;
  reg rx_s2_q;
  always @(posedge core_clk) begin
    if (sys_rst) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
    end else begin
      rx_s1_q <= rx_pin;
      rx_s2_q <= rx_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receiver: 8N1 sampled mid bit
  // A low level at mid start bit confirms the start; a short glitch is dropped
  // Data bits follow one bit time apart, lsb first
  reg rx_act_q;
  reg [3:0] rx_bit_q;
  reg [15:0] rx_cnt_q;
  reg [7:0] rx_sh_q;
  reg rx_stb_q;
  reg [7:0] rx_byte_q;
  always @(posedge core_clk) begin
    if (sys_rst) begin
      rx_act_q <= 1'b0;
      rx_bit_q <= 4'h0;
      rx_cnt_q <= 16'h0000;
      rx_sh_q <= 8'h00;
      rx_stb_q <= 1'b0;
      rx_byte_q <= 8'h00;
    end else begin
      rx_stb_q <= 1'b0;
      if (!rx_act_q) begin
        if (!rx_s2_q) begin
          rx_act_q <= 1'b1;
          rx_bit_q <= 4'h0;
          rx_cnt_q <= HALF_CYC[15:0];
        end
      end else if (rx_cnt_q != 16'h0000) begin
        rx_cnt_q <= rx_cnt_q - 16'h0001;
      end else begin
        rx_cnt_q <= BIT_CYC[15:0] - 16'h0001;
        rx_bit_q <= rx_bit_q + 4'h1;
        if (rx_bit_q == 4'h0) begin
          if (rx_s2_q) begin
            rx_act_q <= 1'b0; // False start
          end
        end else if (rx_bit_q <= 4'h8) begin
          rx_sh_q <= {rx_s2_q, rx_sh_q[7:1]};
        end else begin
          rx_act_q <= 1'b0;
          if (rx_s2_q) begin
            rx_stb_q <= 1'b1; // Framing error drops the byte
            rx_byte_q <= rx_sh_q;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Frame collector: line silence ends a request
  // Length and CRC are held for the cycle in which the decode looks at them
  reg [7:0] fr_q [0:7];
  reg [3:0] fr_len_q;
  reg fr_ovf_q;
  reg [15:0] fr_crc_q;
  reg [31:0] gap_q;
  reg fr_done_q;
  always @(posedge core_clk) begin
    if (sys_rst) begin
      fr_len_q <= 4'h0;
      fr_ovf_q <= 1'b0;
      fr_crc_q <= `WMSR_CRC_INIT;
      gap_q <= 32'h0;
      fr_done_q <= 1'b0;
    end else begin
      fr_done_q <= 1'b0;
      if (fr_done_q) begin
        // Decode has seen the frame; clear for the next one
        gap_q <= 32'h0;
        fr_len_q <= 4'h0;
        fr_ovf_q <= 1'b0;
        fr_crc_q <= `WMSR_CRC_INIT;
      end else if (rx_stb_q) begin
        gap_q <= 32'h0;
        fr_crc_q <= crc_byte(fr_crc_q, rx_byte_q);
        if (fr_len_q < `WMSR_REQ_LEN) begin
          fr_q[fr_len_q[2:0]] <= rx_byte_q;
          fr_len_q <= fr_len_q + 4'h1;
        end else begin
          fr_ovf_q <= 1'b1;
        end
      end else if (rx_act_q) begin
        gap_q <= 32'h0;
      end else if (fr_len_q != 4'h0 || fr_ovf_q) begin
        if (gap_q == GAP_CYC - 1) begin
          fr_done_q <= 1'b1; // Length and CRC still stand next cycle
        end else begin
          gap_q <= gap_q + 32'h1;
        end
      end
    end
  end

  // Request decode; CRC over whole frame incl. its CRC leaves zero
  // A short, long or foreign frame gets no reply and no error frame
  wire [15:0] req_start = {fr_q[2], fr_q[3]};
  wire [15:0] req_count = {fr_q[4], fr_q[5]};
  wire [15:0] req_end = req_start + req_count - 16'h0001;
  wire req_ok = fr_done_q && !fr_ovf_q && fr_len_q == `WMSR_REQ_LEN
    && fr_crc_q == 16'h0000
    && fr_q[0] == `WMSR_DEF_ADDR
    && fr_q[1] == `WMSR_FC_READ
    && req_count != 16'h0000 && req_start >= `WMSR_REG_FIRST
    && req_end <= `WMSR_REG_LAST && req_end >= req_start;

  // Register read mux
  // Values are taken as each register's high byte goes out, so a reply shows fresh data
  // Low-nibble offsets outside the map read as zero; the decode never lets them through
  reg [15:0] reg_val;
  reg [15:0] reg_idx_q;
  always @* begin
    case (reg_idx_q[3:0])
      `WMSR_OFS_AIR_TEMPERATURE: reg_val = air_temperature;
      `WMSR_OFS_AIR_HUMIDITY: reg_val = air_humidity;
      `WMSR_OFS_AIR_PRESSURE: reg_val = air_pressure;
      `WMSR_OFS_WIND_SPEED: reg_val = wind_speed;
      `WMSR_OFS_WIND_DIRECTION: reg_val = wind_direction;
      `WMSR_OFS_RAINFALL_TOTAL: reg_val = rainfall_total;
      `WMSR_OFS_SOLAR_RADIATION: reg_val = solar_radiation;
      `WMSR_OFS_ILLUMINATION: reg_val = illumination;
      `WMSR_OFS_SUNSHINE_DURATION: reg_val = sunshine_duration;
      `WMSR_OFS_DEW_POINT: reg_val = dew_point;
      `WMSR_OFS_EVAPOTRANSPIRATION: reg_val = evapotranspiration;
      default: reg_val = 16'h0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Reply sequencer and transmitter
  reg [3:0] st_q;
  reg [7:0] pos_q;
  reg [7:0] nbytes_q;
  reg [15:0] tx_crc_q;
  reg [15:0] hold_q;
  reg [7:0] tx_byte;
  reg [9:0] tx_sh_q;
  reg [3:0] tx_bit_q;
  reg [15:0] tx_cnt_q;
  // Byte at current reply position: addr, fc, count, data, crc lo, crc hi
  // Low data bytes come from hold_q, so both halves of a register are one sample
  always @* begin
    if (pos_q == 8'h00) begin
      tx_byte = `WMSR_DEF_ADDR;
    end else if (pos_q == 8'h01) begin
      tx_byte = `WMSR_FC_READ;
    end else if (pos_q == 8'h02) begin
      tx_byte = nbytes_q;
    end else if (pos_q < nbytes_q + 8'h03) begin
      tx_byte = pos_q[0] ? reg_val[15:8] : hold_q[7:0];
    end else if (pos_q == nbytes_q + 8'h03) begin
      tx_byte = tx_crc_q[7:0];
    end else begin
      tx_byte = tx_crc_q[15:8];
    end
  end
  always @(posedge core_clk) begin
    if (sys_rst) begin
      st_q <= ST_IDLE;
      pos_q <= 8'h00;
      nbytes_q <= 8'h00;
      tx_crc_q <= `WMSR_CRC_INIT;
      hold_q <= 16'h0000;
      reg_idx_q <= 16'h0000;
      tx_sh_q <= 10'h3ff;
      tx_bit_q <= 4'h0;
      tx_cnt_q <= 16'h0000;
      tx_pin_q <= 1'b1;
      tx_oe_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          tx_pin_q <= 1'b1;
          tx_oe_q <= 1'b0;
          busy_q <= 1'b0;
          if (req_ok) begin
            nbytes_q <= {req_count[6:0], 1'b0};
            reg_idx_q <= req_start;
            pos_q <= 8'h00;
            tx_crc_q <= `WMSR_CRC_INIT;
            busy_q <= 1'b1;
            st_q <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          tx_oe_q <= 1'b1;
          tx_sh_q <= {1'b1, tx_byte, 1'b0};
          // The CRC covers every byte up to the last data byte
          if (pos_q < nbytes_q + 8'h03) begin
            tx_crc_q <= crc_byte(tx_crc_q, tx_byte);
          end
          if (pos_q >= 8'h03 && pos_q[0]) begin
            hold_q <= reg_val;
            reg_idx_q <= reg_idx_q + 16'h0001;
          end
          tx_bit_q <= 4'h0;
          tx_cnt_q <= BIT_CYC[15:0] - 16'h0001;
          st_q <= ST_SEND;
        end
        ST_SEND: begin
          // The pin lags the shifter by one cycle and is itself a flop
          tx_pin_q <= tx_sh_q[0];
          if (tx_cnt_q != 16'h0000) begin
            tx_cnt_q <= tx_cnt_q - 16'h0001;
          end else begin
            tx_cnt_q <= BIT_CYC[15:0] - 16'h0001;
            tx_sh_q <= {1'b1, tx_sh_q[9:1]};
            tx_bit_q <= tx_bit_q + 4'h1;
            if (tx_bit_q == 4'h9) begin
              pos_q <= pos_q + 8'h01;
              st_q <= (pos_q == nbytes_q + 8'h04) ? ST_WAIT : ST_LOAD;
            end
          end
        end
        ST_WAIT: begin
          // Release the line one cycle after the last stop bit
          tx_pin_q <= 1'b1;
          tx_oe_q <= 1'b0;
          busy_q <= 1'b0;
          st_q <= ST_IDLE;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== wmsr_slave_props.sv ====
// Assertions on the serial pins of the weather register slave
`timescale 1ns/1ps
`default_nettype none
module wmsr_props (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Serial pins and status
  input wire logic rx_pin,
  input wire logic tx_pin_q,
  input wire logic tx_oe_q,
  input wire logic busy_q
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Reply framing on the transmit pin, and silence on the receive pin before accept
  property p_rst; $fell(sys_rst) |-> tx_pin_q && !tx_oe_q && !busy_q; endproperty
  a_rst: assert property (p_rst) else $error("bad state after reset");
  property p_idle; !tx_oe_q |-> tx_pin_q; endproperty
  a_idle: assert property (p_idle) else $error("idle line not high");
  property p_oe; tx_oe_q |-> busy_q; endproperty
  a_oe: assert property (p_oe) else $error("driving without a request");
  property p_lead; $rose(busy_q) |=> $rose(tx_oe_q); endproperty
  a_lead: assert property (p_lead) else $error("enable late after accept");
  property p_start; $rose(tx_oe_q) |-> ##[0:1] !tx_pin_q; endproperty
  a_start: assert property (p_start) else $error("no start bit");
  property p_gap; $rose(busy_q) |-> rx_pin && $past(rx_pin, 8); endproperty
  a_gap: assert property (p_gap) else $error("accept without silence");
  property p_end; $fell(tx_oe_q) |-> $fell(busy_q) && $past(tx_pin_q); endproperty
  a_end: assert property (p_end) else $error("reply not ended by stop");
  property p_bit; tx_oe_q && $changed(tx_pin_q) |=> $stable(tx_pin_q) [*8]; endproperty
  a_bit: assert property (p_bit) else $error("bit too short");
  // Main scenarios reached
  c_reply: cover property ($fell(busy_q));
  c_start: cover property ($rose(tx_oe_q));
  c_zero: cover property (tx_oe_q && !tx_pin_q);
endmodule
bind wmsr_slave wmsr_props u_props (.core_clk(core_clk), .sys_rst(sys_rst), .rx_pin(rx_pin),
  .tx_pin_q(tx_pin_q), .tx_oe_q(tx_oe_q), .busy_q(busy_q));
`default_nettype wire

// ==== wmsr_host.sv ====
// Host master model: sends request bytes, decodes reply bytes
`timescale 1ns/1ps
`default_nettype none
module wmsr_host #(parameter int BIT = 50) (
  // Clock
  input wire logic core_clk,
  // Serial lines
  output logic rx_line,
  input wire logic tx_pin,
  input wire logic tx_oe,
  // Decoded reply byte
  output logic [7:0] got,
  output logic got_stb
);
  logic line;
  assign line = tx_oe ? tx_pin : 1'b1; // Bias holds mark when undriven
  initial begin
    rx_line = 1'b1;
    got = 8'h00;
    got_stb = 1'b0;
  end
  // One byte 8N1, lsb first
  task automatic send_byte(input logic [7:0] b);
    for (int i = 0; i < 10; i++) begin
      rx_line <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i - 1];
      repeat (BIT) @(posedge core_clk);
    end
  endtask
  // Sample reply bits at mid-bit; a low stop bit drops the byte
  always begin
    @(posedge core_clk);
    if (line === 1'b0) begin
      repeat (BIT / 2) @(posedge core_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(posedge core_clk);
        got[i] <= line;
      end
      repeat (BIT) @(posedge core_clk);
      got_stb <= line;
      @(posedge core_clk);
      got_stb <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== test_weather_modbus_slave_regs.sv ====
// Self-checking bench for the weather register slave
`timescale 1ns/1ps
`default_nettype none
module test_weather_modbus_slave_regs;
  logic core_clk, sys_rst, rx_pin, tx_pin_q, tx_oe_q, busy_q, got_stb;
  logic [7:0] got;
  logic [15:0] m [1:11];
  logic [7:0] exp_q [$];
  logic [15:0] s;
  int n_mismatch = 0;
  int check_count = 0;
  wmsr_slave #(.CLK_HZ(480000), .BAUD(9600), .GAP_CYC(200)) dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .rx_pin(rx_pin), .tx_pin_q(tx_pin_q), .tx_oe_q(tx_oe_q), .busy_q(busy_q), .air_temperature(m[1]),
    .air_humidity(m[2]), .air_pressure(m[3]), .wind_speed(m[4]), .wind_direction(m[5]), .rainfall_total(m[6]),
    .solar_radiation(m[7]), .illumination(m[8]), .sunshine_duration(m[9]), .dew_point(m[10]),
    .evapotranspiration(m[11]));
  wmsr_host #(.BIT(50)) u_host (.core_clk(core_clk), .rx_line(rx_pin), .tx_pin(tx_pin_q), .tx_oe(tx_oe_q),
    .got(got), .got_stb(got_stb));
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    check_count++;
    if (seen !== want) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  function automatic logic [15:0] crc16(input logic [7:0] b [$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    return c;
  endfunction
  // Send one request; a valid one queues its whole reply, others must get none
  task automatic poll(input logic [7:0] sa, fc, input logic [15:0] st, cnt, input logic bad);
    logic [7:0] f [$];
    logic [7:0] r [$];
    logic [15:0] c;
    int t;
    foreach (m[i]) m[i] <= 16'($urandom);
    @(posedge core_clk);
    f = {sa, fc, st[15:8], st[7:0], cnt[15:8], cnt[7:0]};
    c = crc16(f) ^ {15'h0000, bad};
    f = {f, c[7:0], c[15:8]};
    if (sa == 8'hff && fc == 8'h03 && !bad && st >= 1 && cnt >= 1 && st + cnt <= 12) begin
      r = {8'hff, 8'h03, 8'(cnt * 2)};
      for (int a = st; a < st + cnt; a++) r = {r, m[a][15:8], m[a][7:0]};
      c = crc16(r);
      exp_q = {exp_q, r, c[7:0], c[15:8]};
    end
    foreach (f[i]) u_host.send_byte(f[i]);
    for (t = 0; t < 40000 && (busy_q !== 1'b0 || t < 400); t++) @(posedge core_clk);
    if (t == 40000) begin
      n_mismatch++;
      end_of_test;
    end
    repeat (200) @(posedge core_clk);
    check(16'(exp_q.size()), 16'h0000);
  endtask
  // Compare each reply byte with the oldest queued byte
  always @(posedge core_clk) begin
    if (got_stb === 1'b1) begin
      if (exp_q.size() == 0) check({8'h00, got}, 16'h01ff);
      else check({8'h00, got}, {8'h00, exp_q.pop_front()});
    end
  end
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial begin
    sys_rst = 1'b1;
    foreach (m[i]) m[i] = 16'h0000;
    void'($urandom(12));
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    poll(8'hff, 8'h03, 16'h0001, 16'h000b, 1'b0);
    s = 16'($urandom_range(10, 1));
    poll(8'hff, 8'h03, s, 16'($urandom_range(11 - s, 1)), 1'b0);
    poll(8'hff, 8'h03, 16'h000b, 16'h0001, 1'b0);
    poll(8'hff, 8'h03, 16'h0001, 16'h000b, 1'b1);
    poll(8'h01, 8'h03, 16'h0001, 16'h0001, 1'b0);
    poll(8'hff, 8'h04, 16'h0001, 16'h0001, 1'b0);
    poll(8'hff, 8'h03, 16'h0000, 16'h0001, 1'b0);
    poll(8'hff, 8'h03, 16'h0001, 16'h000c, 1'b0);
    poll(8'hff, 8'h03, 16'h0001, 16'h0000, 1'b0);
    end_of_test;
  end
endmodule
`default_nettype wire
